// ===== src/pmic_fault_event_flags.sv
// Event flags, masks, live status and shutdown causes behind an I2C slave.
// Assumes scl/sda and all event inputs are synchronous to mclk (10 MHz).
`timescale 1ns/1ns
module pmic_fault_event_flags
	import pmic_flags_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// I2C slave pins
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Regulator and temperature monitors
	input wire logic [PGOOD_COUNT-1:0] power_good,
	input wire logic overcurrent_rail_a,
	input wire logic overcurrent_rail_b,
	input wire logic overcurrent_memory_rail,
	input wire logic overcurrent_termination,
	input wire logic temp_above_hot,
	input wire logic temp_above_critical,
	// Shutdown causes from the sequencer
	input wire logic host_pin_off_event,
	input wire logic undervoltage_off_event,
	input wire logic power_fault_off_event,
	input wire logic critical_temp_off_event,
	// Combined interrupt
	output logic irq_out
);
	// ==========================================================
	// State
	typedef struct packed {
		i2c_state_t st;
		logic [7:0] shreg;
		logic [3:0] bitcnt;
		logic [7:0] ptr;
		logic rd;
		logic scl_q;
		logic sda_q;
		logic oe;
		logic drive_lvl;
		logic [7:0] mask;
		logic hot_lvl;
		logic irq;
		logic wr_ev;
		logic wr_cause;
		logic [7:0] wdata;
	} core_state_t;

	localparam core_state_t CORE_RST = '{
		st: ST_IDLE, shreg: 8'h00, bitcnt: 4'h0, ptr: 8'h00, rd: 1'b0,
		scl_q: 1'b1, sda_q: 1'b1, oe: 1'b0, drive_lvl: 1'b0,
		mask: RST_EVENT_MASKS, hot_lvl: RST_LIVE_STATUS[HOT_LEVEL_BIT], irq: 1'b0,
		wr_ev: 1'b0, wr_cause: 1'b0, wdata: 8'h00};

	core_state_t q;
	core_state_t n;

	// ==========================================================
	// Event edges and flag banks
	logic [EDGE_W-1:0] lvl;
	logic [EDGE_W-1:0] rise;
	logic [EDGE_W-1:0] fall;
	logic [7:0] ev_set;
	logic [7:0] cause_set;
	logic [7:0] ev_flags;
	logic [7:0] cause_flags;
	logic fault_hit;
	logic sd_hit;

	assign lvl = {power_good, overcurrent_termination, overcurrent_memory_rail,
		overcurrent_rail_b, overcurrent_rail_a, temp_above_hot, temp_above_critical,
		host_pin_off_event, undervoltage_off_event, power_fault_off_event,
		critical_temp_off_event};

	edge_detect #(.W(EDGE_W)) u_edges (
		.mclk(mclk),
		.reset(reset),
		.level(lvl),
		.rise(rise),
		.fall(fall)
	);

	always_comb begin
		fault_hit = |fall[EDGE_W-1:EDGE_PG_LO];
		fault_hit = fault_hit | (|rise[EDGE_OC_LO+3:EDGE_OC_LO]);
		fault_hit = fault_hit | rise[EDGE_HOT] | rise[EDGE_CRIT];
		// Any shutdown, host pin included, marks the shutdown event
		sd_hit = |rise[EDGE_SD_LO+3:EDGE_SD_LO];
		ev_set = 8'h00;
		ev_set[FAULT_EVENT_BIT] = fault_hit;
		ev_set[SHUTDOWN_EVENT_BIT] = sd_hit;
		ev_set[HOT_TEMPERATURE_BIT] = rise[EDGE_HOT];
		cause_set = {4'h0, rise[EDGE_SD_LO+3:EDGE_SD_LO]};
	end

	// Reserved bits are forced to zero inside the bank
	w1c_bank #(.W(8), .LIVE(EVENT_LIVE_BITS)) u_event_flags (
		.mclk(mclk),
		.reset(reset),
		.set(ev_set),
		.clr_stb(q.wr_ev),
		.clr_data(q.wdata),
		.flags(ev_flags)
	);

	w1c_bank #(.W(8), .LIVE(CAUSE_LIVE_BITS)) u_shutdown_cause (
		.mclk(mclk),
		.reset(reset),
		.set(cause_set),
		.clr_stb(q.wr_cause),
		.clr_data(q.wdata),
		.flags(cause_flags)
	);

	// ==========================================================
	// Register read mux
	function automatic logic [7:0] read_reg(input logic [7:0] ofs, input logic [7:0] ev,
		input logic [7:0] msk, input logic hot, input logic [7:0] cause);
		logic [7:0] r;
		r = 8'h00;
		unique case (ofs)
			OFS_EVENT_FLAGS: r = ev;
			OFS_EVENT_MASKS: r = msk;
			OFS_LIVE_STATUS: r = {7'h00, hot};
			OFS_SHUTDOWN_CAUSE: r = cause;
			default: r = 8'h00;
		endcase
		return r;
	endfunction : read_reg

	// ==========================================================
	// I2C byte engine and register writes
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] rbyte;

	always_comb begin
		n = q;
		n.scl_q = scl;
		n.sda_q = sda_in;
		n.wr_ev = 1'b0;
		n.wr_cause = 1'b0;
		n.drive_lvl = 1'b0;
		n.hot_lvl = temp_above_hot;
		n.irq = |(ev_flags & ~q.mask);
		scl_rise = scl & ~q.scl_q;
		scl_fall = ~scl & q.scl_q;
		bus_start = scl & q.scl_q & q.sda_q & ~sda_in;
		bus_stop = scl & q.scl_q & ~q.sda_q & sda_in;
		rbyte = read_reg(q.ptr, ev_flags, q.mask, q.hot_lvl, cause_flags);
		if (bus_start) begin
			n.st = ST_ADDR;
			n.bitcnt = 4'h0;
			n.oe = 1'b0;
		end else if (bus_stop) begin
			n.st = ST_IDLE;
			n.oe = 1'b0;
		end else begin
			unique case (q.st)
				ST_IDLE: begin
				end
				ST_ADDR, ST_REG, ST_WDATA: begin
					if (scl_rise) begin
						n.shreg = {q.shreg[6:0], sda_in};
						n.bitcnt = q.bitcnt + 4'h1;
					end else if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
						n.bitcnt = 4'h0;
						n.oe = 1'b1;
						if (q.st == ST_ADDR) begin
							// Only our own address is acknowledged
							if (q.shreg[7:1] == DEV_ADDR) begin
								n.rd = q.shreg[0];
								n.st = ST_ADDR_ACK;
							end else begin
								n.oe = 1'b0;
								n.st = ST_IDLE;
							end
						end else if (q.st == ST_REG) begin
							n.ptr = q.shreg;
							n.st = ST_REG_ACK;
						end else begin
							n.wdata = q.shreg;
							n.wr_ev = (q.ptr == OFS_EVENT_FLAGS);
							n.wr_cause = (q.ptr == OFS_SHUTDOWN_CAUSE);
							if (q.ptr == OFS_EVENT_MASKS) begin
								n.mask = (q.shreg & MASK_RW_BITS) | ~MASK_RW_BITS;
							end
							n.ptr = q.ptr + 8'h01;
							n.st = ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (q.rd) begin
							n.shreg = rbyte;
							n.oe = ~rbyte[7];
							n.st = ST_RDATA;
						end else begin
							n.oe = 1'b0;
							n.st = ST_REG;
						end
					end
				end
				ST_REG_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						n.oe = 1'b0;
						n.st = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (q.bitcnt == BITS_PER_BYTE - 4'h1) begin
							n.bitcnt = 4'h0;
							n.oe = 1'b0;
							n.st = ST_RDATA_ACK;
						end else begin
							n.shreg = {q.shreg[6:0], 1'b0};
							n.oe = ~q.shreg[6];
							n.bitcnt = q.bitcnt + 4'h1;
						end
					end
				end
				ST_RDATA_ACK: begin
					if (scl_rise) begin
						if (sda_in) begin
							n.st = ST_IDLE;
						end else begin
							n.ptr = q.ptr + 8'h01;
							n.st = ST_RDATA_NEXT;
						end
					end
				end
				ST_RDATA_NEXT: begin
					if (scl_fall) begin
						n.shreg = rbyte;
						n.oe = ~rbyte[7];
						n.st = ST_RDATA;
					end
				end
				default: begin
					n.oe = 1'b0;
					n.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			q <= CORE_RST;
		end else begin
			q <= n;
		end
	end

	assign sda_out = q.drive_lvl;
	assign sda_oe = q.oe;
	assign irq_out = q.irq;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	AST_FAULT_OVERCURRENT: assert property (
		overcurrent_rail_b && !$past(overcurrent_rail_b) |=> ev_flags[FAULT_EVENT_BIT])
		else $error("Overcurrent did not set fault flag");
	AST_FAULT_PGOOD: assert property (
		|($past(power_good) & ~power_good) |=> ev_flags[FAULT_EVENT_BIT])
		else $error("Power-good loss did not set fault flag");
	AST_HOT_SETS_BOTH: assert property (
		$rose(temp_above_hot) |=> ev_flags[FAULT_EVENT_BIT] && ev_flags[HOT_TEMPERATURE_BIT])
		else $error("Hot crossing did not set fault and hot flags");
	AST_CRIT_FAULT: assert property (
		$rose(temp_above_critical) |=> ev_flags[FAULT_EVENT_BIT])
		else $error("Critical crossing did not set fault flag");
	AST_FAULT_HOLD: assert property (
		ev_flags[FAULT_EVENT_BIT] && !(q.wr_ev && q.wdata[FAULT_EVENT_BIT])
		|=> ev_flags[FAULT_EVENT_BIT])
		else $error("Fault flag dropped without a clear");
	AST_FAULT_CLEAR: assert property (
		q.wr_ev && q.wdata[FAULT_EVENT_BIT] && !fault_hit |=> !ev_flags[FAULT_EVENT_BIT])
		else $error("Writing one did not clear fault flag");
	AST_UV_CAUSE: assert property (
		$rose(undervoltage_off_event)
		|=> cause_flags[UNDERVOLTAGE_OFF_BIT] && ev_flags[SHUTDOWN_EVENT_BIT])
		else $error("Undervoltage shutdown not recorded");
	AST_CAUSE_HOLD: assert property (
		cause_flags[POWER_FAULT_OFF_BIT] && !(q.wr_cause && q.wdata[POWER_FAULT_OFF_BIT])
		|=> cause_flags[POWER_FAULT_OFF_BIT])
		else $error("Cause bit dropped without a clear");
	AST_LIVE_LEVEL: assert property (
		q.hot_lvl == $past(temp_above_hot))
		else $error("Live hot level not following input");
	AST_IRQ_GATE: assert property (
		irq_out == $past(|(ev_flags & ~q.mask)))
		else $error("Interrupt does not match unmasked flags");
	AST_RESERVED_ZERO: assert property (
		(ev_flags & ~EVENT_LIVE_BITS) == 8'h00 && (cause_flags & ~CAUSE_LIVE_BITS) == 8'h00)
		else $error("Reserved flag bits not zero");
	AST_MASK_RESERVED: assert property (
		(q.mask | MASK_RW_BITS) == 8'hff)
		else $error("Reserved mask bits not one");

	COV_ADDR_ACK: cover property (q.st == ST_ADDR_ACK && scl_fall);
	COV_MASK_WRITE: cover property (q.st == ST_WDATA_ACK && q.mask != RST_EVENT_MASKS);
	COV_READ_BYTE: cover property (q.st == ST_RDATA_ACK && scl_rise && !sda_in);
	COV_IRQ_RISE: cover property ($rose(irq_out));
	COV_READ_NEXT: cover property (q.st == ST_RDATA_NEXT && scl_fall);
endmodule : pmic_fault_event_flags

// ===== include/pmic_flags_pkg.sv
// Constants, register map and state encoding for the fault/event flag block.
// Assumes one 10 MHz logic clock and an I2C host on the two-wire port.
package pmic_flags_pkg;

	// ==========================================================
	// Slave port
	localparam logic [6:0] DEV_ADDR = 7'h5e;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h02;
	localparam logic [7:0] OFS_EVENT_MASKS = 8'h03;
	localparam logic [7:0] OFS_LIVE_STATUS = 8'h04;
	localparam logic [7:0] OFS_SHUTDOWN_CAUSE = 8'h05;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
	localparam logic [7:0] RST_EVENT_MASKS = 8'hff;
	localparam logic [7:0] RST_LIVE_STATUS = 8'h00;
	localparam logic [7:0] RST_SHUTDOWN_CAUSE = 8'h00;

	// ==========================================================
	// Field positions
	localparam int FAULT_EVENT_BIT = 7;
	localparam int SHUTDOWN_EVENT_BIT = 3;
	localparam int HOT_TEMPERATURE_BIT = 0;
	localparam int HOT_LEVEL_BIT = 0;
	localparam int HOST_PIN_OFF_BIT = 3;
	localparam int UNDERVOLTAGE_OFF_BIT = 2;
	localparam int POWER_FAULT_OFF_BIT = 1;
	localparam int CRITICAL_TEMP_OFF_BIT = 0;
	// Writable / clearable bits of each register
	localparam logic [7:0] EVENT_LIVE_BITS = 8'h89;
	localparam logic [7:0] MASK_RW_BITS = 8'h89;
	localparam logic [7:0] CAUSE_LIVE_BITS = 8'h0f;

	// ==========================================================
	// Event input vector layout
	localparam int PGOOD_COUNT = 8;
	localparam int EDGE_W = PGOOD_COUNT + 10;
	localparam int EDGE_SD_LO = 0;
	localparam int EDGE_CRIT = 4;
	localparam int EDGE_HOT = 5;
	localparam int EDGE_OC_LO = 6;
	localparam int EDGE_PG_LO = 10;

	// ==========================================================
	// Byte engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_REG = 4'b0011,
		ST_REG_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RDATA_ACK = 4'b1000,
		ST_RDATA_NEXT = 4'b1001
	} i2c_state_t;

endpackage : pmic_flags_pkg

// ===== src/edge_detect.sv
// Rising and falling edge detector for a vector of synchronous levels.
// Assumes inputs are already synchronous to mclk.
`timescale 1ns/1ns
module edge_detect #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Levels in, one-cycle pulses out
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] prev;
	} edge_state_t;

	edge_state_t q;
	edge_state_t n;

	always_comb begin
		n = q;
		n.prev = level;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign rise = level & ~q.prev;
	assign fall = ~level & q.prev;
endmodule : edge_detect

// ===== src/w1c_bank.sv
// Bank of sticky flags: hardware sets, host clears by writing ones.
// Assumes clear strobe and data arrive together for one cycle.
`timescale 1ns/1ns
module w1c_bank #(
	parameter int W = 8,
	parameter logic [W-1:0] LIVE = '1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Set and clear
	input wire logic [W-1:0] set,
	input wire logic clr_stb,
	input wire logic [W-1:0] clr_data,
	// Flag values
	output logic [W-1:0] flags
);
	typedef struct packed {
		logic [W-1:0] val;
	} bank_state_t;

	bank_state_t q;
	bank_state_t n;
	logic [W-1:0] clear;

	always_comb begin
		n = q;
		clear = clr_stb ? (clr_data & LIVE) : '0;
		// Set wins over a clear in the same cycle
		n.val = ((q.val & ~clear) | set) & LIVE;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign flags = q.val;
endmodule : w1c_bank

// ===== verif/i2c_host_model.sv
// Bit-level I2C host with register read and write tasks.
// Assumes the bench resolves SDA with a pull-up from all pull-downs.
`timescale 1ns/1ns
module i2c_host_model
	import pmic_flags_pkg::*;
#(
	parameter int HALF = 3
) (
	// Clock
	input wire logic mclk,
	// Bus
	output logic scl,
	output logic sda_low,
	input wire logic sda_line
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ========
	// Bit and byte level
	task automatic hold;
		repeat (HALF) @(posedge mclk);
	endtask : hold

	// Data changes only while scl is low, read back at the end of the high phase
	task automatic bit_xfer(input logic b, output logic r);
		@(posedge mclk) sda_low <= ~b;
		hold();
		scl <= 1'b1;
		hold();
		r = sda_line;
		scl <= 1'b0;
	endtask : bit_xfer

	// Also serves as repeated start: releases SDA before raising scl
	task automatic start;
		@(posedge mclk) sda_low <= 1'b0;
		hold();
		scl <= 1'b1;
		hold();
		sda_low <= 1'b1;
		hold();
		scl <= 1'b0;
	endtask : start

	task automatic stop;
		@(posedge mclk) sda_low <= 1'b1;
		hold();
		scl <= 1'b1;
		hold();
		sda_low <= 1'b0;
		hold();
	endtask : stop

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(b[i], r);
		bit_xfer(1'b1, r);
		ack = ~r;
	endtask : put_byte

	// Ninth bit is the master's answer: low asks for one more byte
	task automatic get_byte(input logic more, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_xfer(1'b1, b[i]);
		bit_xfer(~more, r);
	endtask : get_byte

	// ========
	// Register level
	task automatic probe(input logic [6:0] addr, output logic ack);
		start();
		put_byte({addr, 1'b0}, ack);
		stop();
	endtask : probe

	task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ack);
		logic a0;
		logic a1;
		logic a2;
		start();
		put_byte({DEV_ADDR, 1'b0}, a0);
		put_byte(ofs, a1);
		put_byte(d, a2);
		stop();
		ack = a0 & a1 & a2;
	endtask : write_reg

	// Repeated start only, pointer kept across it
	task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ack);
		logic a0;
		logic a1;
		logic a2;
		start();
		put_byte({DEV_ADDR, 1'b0}, a0);
		put_byte(ofs, a1);
		start();
		put_byte({DEV_ADDR, 1'b1}, a2);
		get_byte(1'b0, d);
		stop();
		ack = a0 & a1 & a2;
	endtask : read_reg

	// First byte acknowledged, so the pointer steps on to the next register
	task automatic read_pair(input logic [7:0] ofs, output logic [15:0] d, output logic ack);
		logic a0;
		logic a1;
		logic a2;
		start();
		put_byte({DEV_ADDR, 1'b0}, a0);
		put_byte(ofs, a1);
		start();
		put_byte({DEV_ADDR, 1'b1}, a2);
		get_byte(1'b1, d[15:8]);
		get_byte(1'b0, d[7:0]);
		stop();
		ack = a0 & a1 & a2;
	endtask : read_pair
endmodule : i2c_host_model

// ===== verif/pmic_fault_event_flags_tb.sv
// Self-checking bench: host model on I2C, directed and random monitor events.
// Assumes the design carries its own assertions.
`timescale 1ns/1ns
module pmic_fault_event_flags_tb;
	import pmic_flags_pkg::*;

	logic mclk;
	logic reset;
	logic scl;
	logic sda_low;
	logic sda_oe;
	logic sda_out;
	logic irq_out;
	logic [PGOOD_COUNT-1:0] power_good;
	// Overcurrent a,b,mem,term, hot, critical, then the four shutdown causes
	logic [9:0] ev;
	// Pull-up: line is low while either party pulls it
	wire sda_line = ~(sda_low | sda_oe);
	int mismatches;
	int n_tests;
	logic [15:0] lfsr_q;

	pmic_fault_event_flags u_pmic_fault_event_flags (.mclk(mclk), .reset(reset), .scl(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .power_good(power_good),
		.overcurrent_rail_a(ev[0]), .overcurrent_rail_b(ev[1]),
		.overcurrent_memory_rail(ev[2]), .overcurrent_termination(ev[3]),
		.temp_above_hot(ev[4]), .temp_above_critical(ev[5]), .host_pin_off_event(ev[6]),
		.undervoltage_off_event(ev[7]), .power_fault_off_event(ev[8]),
		.critical_temp_off_event(ev[9]), .irq_out(irq_out));

	i2c_host_model u_i2c_host_model (.mclk(mclk), .scl(scl), .sda_low(sda_low),
		.sda_line(sda_line));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ========
	// Helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	// Flags in the upper byte, causes in the lower; kinds 7..10 map to cause bits 3..0
	function automatic logic [15:0] expect_regs(input int k);
		logic [7:0] f;
		logic [7:0] c;
		f = '0;
		c = '0;
		f[FAULT_EVENT_BIT] = (k <= 6);
		f[HOT_TEMPERATURE_BIT] = (k == 5);
		f[SHUTDOWN_EVENT_BIT] = (k >= 7);
		if (k >= 7)
			c[10 - k] = 1'b1;
		return {f, c};
	endfunction : expect_regs

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input string what);
		logic [7:0] d;
		logic a;
		u_i2c_host_model.read_reg(ofs, d, a);
		check("read_ack", a, 1'b1);
		check(what, d, exp);
	endtask : rd

	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic a;
		u_i2c_host_model.write_reg(ofs, d, a);
		check("write_ack", a, 1'b1);
	endtask : wr

	// Kind 0 drops one power-good; others pulse one event line, hot stays high
	task automatic fire(input int k, input int pg);
		@(posedge mclk);
		if (k == 0)
			power_good[pg] <= 1'b0;
		else
			ev[k - 1] <= 1'b1;
		repeat (3) @(posedge mclk);
		power_good <= '1;
		ev <= ev & 10'h010;
		repeat (3) @(posedge mclk);
	endtask : fire

	task automatic results;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	// ========
	// Sequence
	initial begin
		logic [15:0] e;
		logic [7:0] m;
		logic [15:0] pr;
		logic a;
		int k;
		int pg;
		mismatches = 0;
		n_tests = 0;
		lfsr_q = 16'h594e;
		reset = 1'b1;
		power_good = '1;
		ev = '0;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		check("irq_rst", irq_out, 1'b0);
		check("sda_out", sda_out, 1'b0);
		rd(OFS_EVENT_FLAGS, RST_EVENT_FLAGS, "flags_rst");
		rd(OFS_EVENT_MASKS, RST_EVENT_MASKS, "masks_rst");
		rd(OFS_LIVE_STATUS, RST_LIVE_STATUS, "live_rst");
		rd(OFS_SHUTDOWN_CAUSE, RST_SHUTDOWN_CAUSE, "cause_rst");
		u_i2c_host_model.probe(7'h00, a);
		check("gencall_nack", a, 1'b0);
		u_i2c_host_model.probe(DEV_ADDR ^ 7'h01, a);
		check("addr_nack", a, 1'b0);
		wr(8'h06, 8'h5a);
		rd(8'h06, 8'h00, "unmapped");
		wr(OFS_LIVE_STATUS, 8'hff);
		rd(OFS_LIVE_STATUS, 8'h00, "live_ro");
		wr(OFS_EVENT_MASKS, 8'h00);
		rd(OFS_EVENT_MASKS, ~MASK_RW_BITS, "masks_rw");
		u_i2c_host_model.read_pair(OFS_EVENT_MASKS, pr, a);
		check("pair_ack", a, 1'b1);
		check("pair_masks_live", pr, {~MASK_RW_BITS, RST_LIVE_STATUS});
		for (int it = 0; it < 16; it++) begin
			lfsr_q = lfsr_next(lfsr_q);
			k = (it < 11) ? it : int'(lfsr_q[11:8]) % 11;
			pg = int'(lfsr_q[2:0]);
			// Reserved mask bits kept at their default
			m = (it < 11) ? ((it % 2 == 1) ? 8'hff : 8'h76) : (lfsr_q[15:8] | 8'h76);
			wr(OFS_EVENT_MASKS, m);
			e = expect_regs(k);
			fire(k, pg);
			check("irq_set", irq_out, |(e[15:8] & ~m));
			rd(OFS_EVENT_FLAGS, e[15:8], "flags");
			rd(OFS_SHUTDOWN_CAUSE, e[7:0], "cause");
			if (k == 5) begin
				rd(OFS_LIVE_STATUS, 8'h01, "live_hot");
				@(posedge mclk) ev <= '0;
				repeat (3) @(posedge mclk);
				rd(OFS_LIVE_STATUS, 8'h00, "live_cool");
			end
			wr(OFS_EVENT_FLAGS, 8'h00);
			wr(OFS_SHUTDOWN_CAUSE, 8'h00);
			rd(OFS_EVENT_FLAGS, e[15:8], "flags_w0");
			rd(OFS_SHUTDOWN_CAUSE, e[7:0], "cause_w0");
			wr(OFS_EVENT_FLAGS, 8'hff);
			wr(OFS_SHUTDOWN_CAUSE, 8'hff);
			rd(OFS_EVENT_FLAGS, 8'h00, "flags_w1");
			rd(OFS_SHUTDOWN_CAUSE, 8'h00, "cause_w1");
			check("irq_clr", irq_out, 1'b0);
		end
		results();
	end

	// Roughly twice the expected run
	initial begin
		repeat (90000) @(posedge mclk);
		mismatches++;
		results();
	end
endmodule : pmic_fault_event_flags_tb
